// ==== gen1_ts_watcher.sv ====
// Older-generation link partner model that counts received symbol 4 values with new bits set.
`timescale 1ns/1ps
`default_nettype none

module gen1_ts_watcher
   import port_phy_tx_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic [7:0] i_ts_sym4,
   input  wire logic       i_ts_sym4_valid,
   output logic [7:0]      o_new_bits_seen
);
   // An older partner misreads these bits, so each sighting is counted.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_new_bits_seen <= 8'h00;
      end else if (i_ts_sym4_valid && (i_ts_sym4 & TS_NEW_BITS) != 8'h00) begin
         o_new_bits_seen <= o_new_bits_seen + 8'h01;
      end
   end
endmodule : gen1_ts_watcher
`default_nettype wire

// ==== port_compat_ctl.sv ====
// Legacy compatibility mode control and training set symbol 4 masking for one port.
`timescale 1ns/1ps
`default_nettype none

module port_compat_ctl
   import port_phy_tx_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic       i_legacy_compat_enable,
   input  wire logic       i_full_link_retrain,
   input  wire logic [7:0] i_ts_sym4,
   input  wire logic       i_ts_sym4_valid,
   output logic            o_compat_active,
   output logic [7:0]      o_ts_sym4,
   output logic            o_ts_sym4_valid
);
   typedef enum logic [1:0] {
      COMPAT_OFF = 2'b01,
      COMPAT_ON  = 2'b10
   } compat_state_t;

   typedef struct packed {
      compat_state_t mode;
      logic [7:0]    sym;
      logic          valid;
   } compat_t;

   compat_t st_q;
   compat_t st_d;

   always_comb begin
      st_d = st_q;
      // The enable bit only takes effect on a full retrain.
      if (i_full_link_retrain) begin
         st_d.mode = i_legacy_compat_enable ? COMPAT_ON : COMPAT_OFF;
      end
      unique case (st_q.mode)
         COMPAT_ON:  st_d.sym = i_ts_sym4 & ~TS_NEW_BITS;
         COMPAT_OFF: st_d.sym = i_ts_sym4;
         default:    st_d.sym = i_ts_sym4;
      endcase
      st_d.valid = i_ts_sym4_valid;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st_q <= '{mode: COMPAT_OFF, sym: 8'h00, valid: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign o_compat_active = (st_q.mode == COMPAT_ON);
   assign o_ts_sym4       = st_q.sym;
   assign o_ts_sym4_valid = st_q.valid;

   a_compat_enter: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_full_link_retrain && i_legacy_compat_enable |=> o_compat_active)
      else $error("Compatibility mode not entered after retrain.");
   a_compat_exit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_full_link_retrain && !i_legacy_compat_enable |=> !o_compat_active ##0
      (!i_ts_sym4_valid or (i_full_link_retrain or 1'b1)))
      else $error("Compatibility mode not left after retrain.");
   a_compat_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_full_link_retrain |=> $stable(o_compat_active))
      else $error("Compatibility mode changed without a retrain.");
   a_ts_bits_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $past(o_compat_active) && o_ts_sym4_valid |-> (o_ts_sym4 & TS_NEW_BITS) == 8'h00)
      else $error("New training set bits sent in compatibility mode.");
   a_ts_pass: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !o_compat_active |=> o_ts_sym4 == $past(i_ts_sym4))
      else $error("Training set symbol altered outside compatibility mode.");

endmodule : port_compat_ctl

`default_nettype wire

// ==== port_phy_tx_config.sv ====
// Transmitter configuration for one even/odd port pair and its two quads.
`timescale 1ns/1ps
`default_nettype none

module port_phy_tx_config
   import port_phy_tx_pkg::*;
#(
   parameter int PAIR_INDEX = 0
)
(
   input  wire logic                                         i_clk_sys,
   input  wire logic                                         i_rst_n,
   input  wire logic                                         i_merge_x8,
   input  wire logic [1:0]                                   i_legacy_compat_enable,
   input  wire logic [1:0]                                   i_full_link_retrain,
   input  wire logic [1:0][7:0]                              i_ts_sym4,
   input  wire logic [1:0]                                   i_ts_sym4_valid,
   input  wire port_phy_tx_pkg::port_ctl_t [1:0]             i_port_ctl,
   input  wire port_phy_tx_pkg::lane_set_t [port_phy_tx_pkg::PAIR_LANES-1:0]
                                           [port_phy_tx_pkg::NUM_MODES-1:0] i_lane_sets,
   output logic [1:0]                                        o_compat_active,
   output logic [1:0][7:0]                                   o_ts_sym4,
   output logic [1:0]                                        o_ts_sym4_valid,
   output logic [1:0][port_phy_tx_pkg::PORT_NUM_W-1:0]       o_quad_port,
   output port_phy_tx_pkg::tx_mode_t [1:0]                   o_quad_mode,
   output logic [1:0]                                        o_mode_load,
   output logic [1:0]                                        o_deemph_3p5,
   output port_phy_tx_pkg::lane_drv_t [port_phy_tx_pkg::PAIR_LANES-1:0] o_lane_drv
);
   import port_phy_tx_pkg::*;

   localparam int QUAD0 = 2 * PAIR_INDEX;
   localparam int QUAD1 = QUAD0 + 1;
   localparam logic [PORT_NUM_W-1:0] PORT_EVEN = PORT_NUM_W'(QUAD0);
   localparam logic [PORT_NUM_W-1:0] PORT_ODD  = PORT_NUM_W'(QUAD1);

   // Quads 10 and 11 do not exist, so that pair cannot be built.
   if (QUAD1 > QUAD_INDEX_MAX || PAIR_INDEX < 0 ||
       (QUAD0 >= QUAD_ABSENT_LO && QUAD0 <= QUAD_ABSENT_HI)) begin : g_bad_pair
      $error("PAIR_INDEX selects an absent quad pair.");
   end

   typedef struct packed {
      logic                        boot_done;
      logic [1:0]                  deemph_3p5;
      tx_mode_t [1:0]              quad_mode;
      logic [1:0][MARGIN_W-1:0]    quad_margin;
      logic [1:0][PORT_NUM_W-1:0]  quad_port;
      logic [1:0]                  mode_load;
   } top_state_t;

   top_state_t st_q;
   top_state_t st_d;

   function automatic tx_mode_t pick_mode(input port_ctl_t c, input logic de35);
      if (c.low_swing) begin
         pick_mode = c.gen2_rate ? MODE_LS_G2 : MODE_LS_G1;
      end else if (!c.gen2_rate) begin
         pick_mode = MODE_FS3_G1;
      end else begin
         pick_mode = de35 ? MODE_FS3_G2 : MODE_FS6_G2;
      end
   endfunction : pick_mode

   always_comb begin
      st_d = st_q;
      // The selectable de-emphasis bit is sampled once after reset release.
      if (!st_q.boot_done) begin
         st_d.boot_done     = 1'b1;
         st_d.deemph_3p5[0] = i_port_ctl[0].sel_deemph_3p5;
         st_d.deemph_3p5[1] = i_port_ctl[1].sel_deemph_3p5;
      end
      for (int q = 0; q < QUADS_PER_PAIR; q++) begin
         // A merged link is steered wholly by the even port.
         if (i_merge_x8) begin
            st_d.quad_port[q]   = PORT_EVEN;
            st_d.quad_mode[q]   = pick_mode(i_port_ctl[0], st_q.deemph_3p5[0]);
            st_d.quad_margin[q] = i_port_ctl[0].margin;
         end else begin
            st_d.quad_port[q]   = (q == 0) ? PORT_EVEN : PORT_ODD;
            st_d.quad_mode[q]   = pick_mode(i_port_ctl[q], st_q.deemph_3p5[q]);
            st_d.quad_margin[q] = i_port_ctl[q].margin;
         end
         st_d.mode_load[q] = (st_d.quad_mode[q] != st_q.quad_mode[q]);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st_q <= '{boot_done: 1'b0, deemph_3p5: 2'b11,
                   quad_mode: {MODE_FS3_G1, MODE_FS3_G1},
                   quad_margin: '0,
                   quad_port: {PORT_ODD, PORT_EVEN},
                   mode_load: 2'b00};
      end else begin
         st_q <= st_d;
      end
   end

   assign o_quad_port  = st_q.quad_port;
   assign o_quad_mode  = st_q.quad_mode;
   assign o_mode_load  = st_q.mode_load;
   assign o_deemph_3p5 = st_q.deemph_3p5;

   for (genvar p = 0; p < 2; p++) begin : g_port
      port_compat_ctl u_compat (
         .i_clk_sys              (i_clk_sys),
         .i_rst_n                (i_rst_n),
         .i_legacy_compat_enable (i_legacy_compat_enable[p]),
         .i_full_link_retrain    (i_full_link_retrain[p]),
         .i_ts_sym4              (i_ts_sym4[p]),
         .i_ts_sym4_valid        (i_ts_sym4_valid[p]),
         .o_compat_active        (o_compat_active[p]),
         .o_ts_sym4              (o_ts_sym4[p]),
         .o_ts_sym4_valid        (o_ts_sym4_valid[p])
      );
   end

   // Every lane has its own stored settings; only mode and margin are shared.
   for (genvar l = 0; l < PAIR_LANES; l++) begin : g_lane
      tx_lane_drive u_lane (
         .i_clk_sys (i_clk_sys),
         .i_rst_n   (i_rst_n),
         .i_sets    (i_lane_sets[l]),
         .i_mode    (st_q.quad_mode[l / LANES_PER_QUAD]),
         .i_margin  (st_q.quad_margin[l / LANES_PER_QUAD]),
         .o_drv     (o_lane_drv[l])
      );
   end

   // Helper terms for the checks below.
   logic all_half;
   logic all_margin;
   always_comb begin
      all_half   = 1'b1;
      all_margin = 1'b1;
      for (int l = 0; l < PAIR_LANES; l++) begin
         all_half   = all_half & o_lane_drv[l].half_swing & (o_lane_drv[l].nominal == DE_0DB);
         all_margin = all_margin &
                      (o_lane_drv[l].set.level == margin_level(i_port_ctl[0].margin));
      end
   end

   // Previous margin of the even port, so the check can tell a settled margin.
   logic [MARGIN_W-1:0] margin0_prev_q;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         margin0_prev_q <= MARGIN_NORMAL;
      end else begin
         margin0_prev_q <= i_port_ctl[0].margin;
      end
   end

   logic merged_ls;
   logic merged_margin;
   assign merged_ls     = i_merge_x8 && i_port_ctl[0].low_swing;
   assign merged_margin = i_merge_x8 && i_port_ctl[0].margin != MARGIN_NORMAL &&
                          (i_port_ctl[0].margin == margin0_prev_q);

   a_x4_quad_port: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_merge_x8 |=> o_quad_port[0] == PORT_EVEN && o_quad_port[1] == PORT_ODD)
      else $error("x4 quad not owned by its own port.");
   a_merge_quad_port: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_merge_x8 |=> o_quad_port[0] == PORT_EVEN && o_quad_port[1] == PORT_EVEN)
      else $error("Merged port does not own both quads.");
   a_boot_deemph: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      st_q.boot_done |=> $stable(o_deemph_3p5))
      else $error("Selectable de-emphasis changed after boot.");
   a_low_swing_all: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      merged_ls [*2] |=> all_half)
      else $error("Low-swing not applied to all lanes of the link.");
   a_margin_all: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      merged_margin [*3] |-> all_margin)
      else $error("Margin did not set every lane of the merged port.");
   a_mode_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $past(i_rst_n) |-> o_mode_load[0] == (o_quad_mode[0] != $past(o_quad_mode[0])))
      else $error("Mode change not flagged as a settings load.");

   c_merged_low_swing: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      merged_ls [*2] ##1 all_half);
   c_margin_merged: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      merged_margin [*3]);
   c_mode_gen2: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_mode_load[0] && o_quad_mode[0] == MODE_FS6_G2);
   c_compat_on: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_compat_active[0]));

endmodule : port_phy_tx_config

`default_nettype wire

// ==== port_phy_tx_config_tb.sv ====
// Self-checking testbench for the transmitter configuration block of one port pair.
`timescale 1ns/1ps
`default_nettype none

module port_phy_tx_config_tb;
   import port_phy_tx_pkg::*;
   logic                                       clk_sys, rst_n, merge;
   logic [1:0]                                 en, rtr, sv, dsel, act, tsv, mload, de35;
   logic [1:0][7:0]                            sym, tso;
   port_ctl_t [1:0]                            ctl;
   lane_set_t [PAIR_LANES-1:0][NUM_MODES-1:0] sets;
   logic [1:0][PORT_NUM_W-1:0]                 qport;
   tx_mode_t [1:0]                             qmode;
   lane_drv_t [PAIR_LANES-1:0]                 drv;
   logic [7:0]                                 seen;
   int                                         mismatches, n_tests, cyc;

   port_phy_tx_config #(.PAIR_INDEX(0)) i_port_phy_tx_config (
      .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_merge_x8(merge),
      .i_legacy_compat_enable(en), .i_full_link_retrain(rtr), .i_ts_sym4(sym),
      .i_ts_sym4_valid(sv), .i_port_ctl(ctl), .i_lane_sets(sets),
      .o_compat_active(act), .o_ts_sym4(tso), .o_ts_sym4_valid(tsv),
      .o_quad_port(qport), .o_quad_mode(qmode), .o_mode_load(mload),
      .o_deemph_3p5(de35), .o_lane_drv(drv));

   gen1_ts_watcher i_gen1_ts_watcher (
      .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_ts_sym4(tso[0]),
      .i_ts_sym4_valid(tsv[0]), .o_new_bits_seen(seen));

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic done(input string s);
      $display("test %s ended, mismatches %0d", s, mismatches);
   endtask : done

   task automatic send(input int p, input logic [7:0] v, input logic [7:0] e);
      sym[p] = v;
      sv[p] = 1'b1;
      tick(1);
      chk(32'(tsv[p]), 32'h1);
      chk(32'(tso[p]), 32'(e));
      sv[p] = 1'b0;
      tick(1);
   endtask : send

   task automatic retrain(input int p);
      rtr[p] = 1'b1;
      tick(1);
      rtr[p] = 1'b0;
      tick(1);
   endtask : retrain

   function automatic lane_drv_t exp_drv(input int l, input port_ctl_t c, input int m);
      lane_drv_t e;
      e.set = sets[l][m];
      if (e.set.level > LEVEL_MAX_CODE) begin
         e.set.level = LEVEL_MAX_CODE;
      end
      if (c.margin != MARGIN_NORMAL) begin
         e.set.level = LEVEL_W'(32'(LEVEL_MAX_CODE) - 2 * 32'(c.margin));
      end
      e.nominal = c.low_swing ? DE_0DB : (m == 2 ? DE_6P0 : DE_3P5);
      e.half_swing = c.low_swing;
      if (c.low_swing) begin
         e.set.coarse_de = 3'h0;
         e.set.fine_de = 3'h0;
      end
      return e;
   endfunction : exp_drv

   task automatic check_all(input logic mg);
      port_ctl_t c;
      logic      d;
      int        m;
      for (int q = 0; q < 2; q++) begin
         c = (mg || q == 0) ? ctl[0] : ctl[1];
         d = (mg || q == 0) ? dsel[0] : dsel[1];
         m = c.low_swing ? (c.gen2_rate ? 4 : 3) : (c.gen2_rate ? (d ? 1 : 2) : 0);
         chk(32'(qmode[q]), 32'h1 << m);
         chk(32'(qport[q]), mg ? 32'h0 : 32'(q));
         for (int l = 4 * q; l < 4 * q + 4; l++) begin
            chk(32'(drv[l]), 32'(exp_drv(l, c, m)));
         end
      end
   endtask : check_all

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         print_verdict();
      end
   end

   initial begin
      {cyc, mismatches, n_tests} = '0;
      {rst_n, merge, en, rtr, sv, sym, ctl} = '0;
      ctl[0].sel_deemph_3p5 = 1'b1;
      ctl[1].sel_deemph_3p5 = 1'b1;
      dsel = 2'h3;
      for (int l = 0; l < PAIR_LANES; l++) begin
         for (int m = 0; m < NUM_MODES; m++) begin
            sets[l][m] = '{5'(2 * l + m), 2'(m), 3'(l), 3'(m), 2'(l), 2'(m)};
         end
      end
      sets[7][0].level = 5'h1F;
      tick(8);
      chk(32'(drv[6].set.boost), 32'(BOOST_RESET));
      chk(32'(drv[1].set.level), 32'h14);
      chk(32'(qport), 32'h10);
      rst_n = 1'b1;
      done("reset");
      for (int p = 0; p < 2; p++) begin
         send(p, 8'hFF, 8'hFF);
         en[p] = 1'b1;
         tick(1);
         send(p, 8'hFF, 8'hFF);
         chk(32'(act[p]), 32'h0);
         retrain(p);
         chk(32'(act[p]), 32'h1);
         send(p, 8'hFF, 8'h3B);
         en[p] = 1'b0;
         tick(1);
         send(p, 8'hFF, 8'h3B);
         retrain(p);
         chk(32'(act[p]), 32'h0);
         send(p, 8'hFF, 8'hFF);
      end
      chk(32'(seen), 32'h3);
      done("compat");
      check_all(1'b0);
      ctl[0].gen2_rate = 1'b1;
      tick(1);
      chk(32'(mload), 32'h1);
      tick(1);
      chk(32'(mload), 32'h0);
      sets[2][1] = '{5'h09, 2'h3, 3'h5, 3'h6, 2'h1, 2'h2};
      tick(2);
      check_all(1'b0);
      done("lanes");
      for (int m = 0; m < 8; m++) begin
         ctl[1].margin = 3'(m);
         tick(3);
         check_all(1'b0);
      end
      ctl[0].low_swing = 1'b1;
      tick(3);
      check_all(1'b0);
      merge = 1'b1;
      tick(3);
      check_all(1'b1);
      ctl[0].margin = 3'h2;
      tick(3);
      check_all(1'b1);
      done("margin");
      rst_n = 1'b0;
      {merge, ctl} = '0;
      ctl[0].sel_deemph_3p5 = 1'b1;
      ctl[1].gen2_rate = 1'b1;
      tick(2);
      rst_n = 1'b1;
      tick(1);
      ctl[1].sel_deemph_3p5 = 1'b1;
      dsel = 2'h1;
      tick(3);
      chk(32'(de35), 32'h1);
      check_all(1'b0);
      done("deemph");
      print_verdict();
   end
endmodule : port_phy_tx_config_tb
`default_nettype wire

// ==== port_phy_tx_pkg.sv ====
// Shared constants and types for the per-port transmitter configuration block.
package port_phy_tx_pkg;

   // Quad and port geometry.
   localparam int QUAD_INDEX_MAX = 13;
   localparam int QUAD_ABSENT_LO = 10;
   localparam int QUAD_ABSENT_HI = 11;
   localparam int LANES_PER_QUAD = 4;
   localparam int QUADS_PER_PAIR = 2;
   localparam int PAIR_LANES     = LANES_PER_QUAD * QUADS_PER_PAIR;
   localparam int PORT_NUM_W     = 4;

   // Drive level: code 0 is the lowest level, each code adds one step.
   localparam int LEVEL_W       = 5;
   localparam int LEVEL_HI_MV   = 950;
   localparam int LEVEL_LO_MV   = 120;
   localparam int LEVEL_STEP_MV = 40;
   localparam logic [LEVEL_W-1:0] LEVEL_MAX_CODE =
      LEVEL_W'((LEVEL_HI_MV - LEVEL_LO_MV) / LEVEL_STEP_MV);

   // Amplitude boost: four settings, reset to the second.
   localparam int BOOST_W = 2;
   localparam logic [BOOST_W-1:0] BOOST_RESET = 2'h1;

   // De-emphasis adjust and slew field widths.
   localparam int DE_W   = 3;
   localparam int SLEW_W = 2;

   // Transmit margin field; the normal operating range is code zero.
   localparam int MARGIN_W = 3;
   localparam logic [MARGIN_W-1:0] MARGIN_NORMAL    = 3'h0;
   localparam logic [LEVEL_W-1:0]  MARGIN_STEP_CODE = 5'h2;

   // Training set symbol 4 bits that are new since the older generation.
   localparam logic [7:0] TS_NEW_BITS = 8'hC4;

   // Driver operating modes; each has its own stored lane settings.
   localparam int NUM_MODES = 5;
   typedef enum logic [NUM_MODES-1:0] {
      MODE_FS3_G1 = 5'b00001,
      MODE_FS3_G2 = 5'b00010,
      MODE_FS6_G2 = 5'b00100,
      MODE_LS_G1  = 5'b01000,
      MODE_LS_G2  = 5'b10000
   } tx_mode_t;

   typedef enum logic [1:0] {
      DE_0DB  = 2'h0,
      DE_3P5  = 2'h1,
      DE_6P0  = 2'h2
   } deemph_nom_t;

   typedef struct packed {
      logic [LEVEL_W-1:0] level;
      logic [BOOST_W-1:0] boost;
      logic [DE_W-1:0]    coarse_de;
      logic [DE_W-1:0]    fine_de;
      logic [SLEW_W-1:0]  slew;
      logic [SLEW_W-1:0]  fine_slew;
   } lane_set_t;

   typedef struct packed {
      logic                low_swing;
      logic                gen2_rate;
      logic                sel_deemph_3p5;
      logic [MARGIN_W-1:0] margin;
   } port_ctl_t;

   typedef struct packed {
      lane_set_t   set;
      deemph_nom_t nominal;
      logic        half_swing;
   } lane_drv_t;

   function automatic logic [LEVEL_W-1:0] margin_level(input logic [MARGIN_W-1:0] m);
      margin_level = LEVEL_W'(LEVEL_MAX_CODE - MARGIN_STEP_CODE * LEVEL_W'(m));
   endfunction : margin_level

endpackage : port_phy_tx_pkg

// ==== tx_lane_drive.sv ====
// Driver settings for one transmit lane, chosen by operating mode and margin.
`timescale 1ns/1ps
`default_nettype none

module tx_lane_drive
   import port_phy_tx_pkg::*;
(
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst_n,
   input  wire lane_set_t [NUM_MODES-1:0] i_sets,
   input  wire tx_mode_t                  i_mode,
   input  wire logic [MARGIN_W-1:0]       i_margin,
   output lane_drv_t                      o_drv
);
   lane_drv_t st_q;
   lane_drv_t st_d;
   lane_set_t sel;

   always_comb begin
      sel  = i_sets[0];
      st_d = st_q;
      // Each mode has its own stored settings, applied on the clock edge after the mode moves.
      unique case (i_mode)
         MODE_FS3_G1: sel = i_sets[0];
         MODE_FS3_G2: sel = i_sets[1];
         MODE_FS6_G2: sel = i_sets[2];
         MODE_LS_G1:  sel = i_sets[3];
         MODE_LS_G2:  sel = i_sets[4];
         default:     sel = i_sets[0];
      endcase
      st_d.set = sel;
      if (sel.level > LEVEL_MAX_CODE) begin
         st_d.set.level = LEVEL_MAX_CODE;
      end
      if (i_margin != MARGIN_NORMAL) begin
         st_d.set.level = margin_level(i_margin);
      end
      st_d.half_swing = 1'b0;
      unique case (i_mode)
         MODE_FS3_G1, MODE_FS3_G2: st_d.nominal = DE_3P5;
         MODE_FS6_G2:              st_d.nominal = DE_6P0;
         MODE_LS_G1, MODE_LS_G2: begin
            st_d.nominal       = DE_0DB;
            st_d.set.coarse_de = '0;
            st_d.set.fine_de   = '0;
            st_d.half_swing    = 1'b1;
         end
         default:                  st_d.nominal = DE_3P5;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st_q <= '{set: '{level: LEVEL_MAX_CODE, boost: BOOST_RESET, coarse_de: 3'h0,
                          fine_de: 3'h0, slew: 2'h0, fine_slew: 2'h0},
                   nominal: DE_3P5, half_swing: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign o_drv = st_q;

   a_level_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_drv.set.level <= LEVEL_MAX_CODE)
      else $error("Drive level code above range.");
   a_boost_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> o_drv.set.boost == BOOST_RESET)
      else $error("Amplitude boost not at second setting after reset.");
   a_low_swing_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_mode == MODE_LS_G1 || i_mode == MODE_LS_G2) |=> o_drv.nominal == DE_0DB
      && o_drv.set.coarse_de == 3'h0 && o_drv.set.fine_de == 3'h0 && o_drv.half_swing)
      else $error("De-emphasis not zero in low-swing mode.");
   a_margin_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_margin != MARGIN_NORMAL |=> o_drv.set.level == margin_level($past(i_margin)))
      else $error("Margin did not set the drive level.");
   a_follow_now: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_margin == MARGIN_NORMAL && i_mode == MODE_FS3_G2 |=>
      o_drv.set.slew == $past(i_sets[1].slew) && o_drv.set.fine_de == $past(i_sets[1].fine_de)
      && o_drv.set.boost == $past(i_sets[1].boost))
      else $error("Lane setting change not applied within one cycle.");

endmodule : tx_lane_drive

`default_nettype wire
